// File: aco_pkg.sv
// Constants shared by the first analog comparator control block.
// Assumes a single system clock and byte-wide register data.
`default_nettype none

package aco_pkg;

  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 8;
  localparam int N_INPUT = 4;
  localparam int SEL_W   = 2;

  // Register offsets on the plain register port.
  localparam logic [ADDR_W-1:0] CTRL_ADDR     = 8'h00;
  localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 8'h01;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 8'h02;

  // Field positions of comparator_one_control.
  localparam int EN_BIT   = 7;
  localparam int RES_BIT  = 6;
  localparam int DRV_BIT  = 5;
  localparam int INV_BIT  = 4;
  localparam int FAST_BIT = 3;
  localparam int REF_BIT  = 2;
  localparam int SEL_LSB  = 0;

  // Field position of the change flag in the status and mask registers.
  localparam int CHG_BIT = 0;

  // Direction bit of the shared port B pin.
  localparam int PORTB_PIN = 6;

  // Reset values and writable bits.
  localparam logic [DATA_W-1:0] CTRL_RST     = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_WR_MASK = 8'hBF;
  localparam logic [DATA_W-1:0] IRQ_RST      = 8'h00;
  localparam logic [DATA_W-1:0] RD_IDLE      = 8'h00;
  localparam logic [N_INPUT-1:0] SEL_ONE     = 4'h1;

  // Result of the comparator after enable and polarity are applied.
  function automatic logic aco_eval(input logic raw,
                                    input logic en,
                                    input logic inv);
    aco_eval = en & (raw ^ inv);
  endfunction

endpackage

`default_nettype wire

// File: aco_irq_if.sv
// Interface between the comparator control logic and its change flag.
// Assumes both ends run on the same clock.
`default_nettype none

interface aco_irq_if;
  logic evt;
  logic clr;
  logic mask;
  logic status;
  logic irq;

  modport ctl (output evt, output clr, output mask,
               input status, input irq);
  modport flag (input evt, input clr, input mask,
                output status, output irq);
endinterface

`default_nettype wire

// File: aco_sync.sv
// Three-stage synchroniser for the asynchronous comparator output.
// Assumes the input may change at any time relative to the clock.
`default_nettype none

module aco_sync
  import aco_pkg::*;
(
  input  wire logic clk_sys_in,
  input  wire logic reset_n_in,
  input  wire logic ce_in,
  input  wire logic async_in,
  output logic      sync_out
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic next_sync;

  // The output moves only when the second and third stages agree.
  always_comb
  begin
    next_sync = sync_out;
    if (stage2 == stage3)
      next_sync = stage3;
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      stage1   <= 1'b0;
      stage2   <= 1'b0;
      stage3   <= 1'b0;
      sync_out <= 1'b0;
    end
    else if (ce_in)
    begin
      stage1   <= async_in;
      stage2   <= stage1;
      stage3   <= stage2;
      sync_out <= next_sync;
    end
  end

endmodule

`default_nettype wire

// File: aco_irq.sv
// Sticky change flag with mask gating onto one level interrupt.
// Assumes the event and clear arrive as single-cycle pulses.
`default_nettype none

module aco_irq
  import aco_pkg::*;
(
  input  wire logic  clk_sys_in,
  input  wire logic  reset_n_in,
  input  wire logic  ce_in,
  aco_irq_if.flag    irq_bus
);

  logic next_status;
  logic next_irq;

  // A change in the same cycle as a clear keeps the flag set.
  always_comb
  begin
    next_status = irq_bus.status;
    if (irq_bus.clr)
      next_status = 1'b0;
    if (irq_bus.evt)
      next_status = 1'b1;
    next_irq = next_status & irq_bus.mask;
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      irq_bus.status <= 1'b0;
      irq_bus.irq    <= 1'b0;
    end
    else if (ce_in)
    begin
      irq_bus.status <= next_status;
      irq_bus.irq    <= next_irq;
    end
  end

  a_set_wins: assert property (@(posedge clk_sys_in)  // [RULE13]
    disable iff (!reset_n_in)
    (ce_in && irq_bus.evt) |=> irq_bus.status)
    else $error("Change event did not set the flag.");

endmodule

`default_nettype wire

// File: aco_top.sv
// Control, status and interrupt logic of the first analog comparator.
// Assumes the analog comparator drives cmp_raw_in asynchronously and
// that the instruction-cycle strobe is a one-cycle pulse on clk_sys_in.
//
// Contract
// [RULE1] Device reset returns every control register to its reset value.
// [RULE2] Enable bit 7 turns the comparator on when set, off when clear.
// [RULE3] Two-bit select at bits 1:0 picks one of analog pins four to seven.
// [RULE4] Software makes the chosen upper analog pins analog before use.
// [RULE5] Reference bit 2 one selects DAC, zero selects external reference.
// [RULE6] Result is readable as read-only bit 6 of the control register.
// [RULE7] Result drives its pin only while pin drive bit 5 is set.
// [RULE8] Clear polarity: one when positive input wins; set polarity inverts.
// [RULE9] Internal result latched per instruction cycle; pin path not latched.
// [RULE10] Change interrupt works the same with pin drive set or clear.
// [RULE11] Pin drives only with switch-mode controller off and direction zero.
// [RULE12] Speed bit 3 set gives normal speed, clear gives low power.
// [RULE13] A latched result change sets a flag that can wake from sleep.
// [RULE14] Select codes 00 to 11 route analog pins four to seven.
`default_nettype none

module aco_top
  import aco_pkg::*;
(
  input  wire logic                clk_sys_in,
  input  wire logic                reset_n_in,
  input  wire logic                ce_in,
  input  wire logic [ADDR_W-1:0]   reg_addr_in,
  input  wire logic [DATA_W-1:0]   reg_wdata_in,
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  output logic      [DATA_W-1:0]   reg_rdata_out,
  input  wire logic                cmp_raw_in,
  input  wire logic                instr_cycle_end_in,
  input  wire logic [DATA_W-1:0]   portb_direction_in,
  input  wire logic                switch_mode_controller_on_in,
  output logic                     cmp_one_enable_out,
  output logic                     cmp_one_fast_out,
  output logic                     cmp_one_ref_sel_out,
  output logic      [N_INPUT-1:0]  cmp_one_input_sel_out,
  output logic                     cmp_pin_out,
  output logic                     cmp_pin_oe_out,
  output logic                     irq_out,
  output logic                     wake_out
);

  aco_irq_if irq_bus ();

  logic                raw_sync;
  logic [DATA_W-1:0]   ctrl;
  logic [DATA_W-1:0]   next_ctrl;
  logic                result_q;
  logic                next_result;
  logic                irq_mask;
  logic                next_mask;
  logic [N_INPUT-1:0]  next_input_sel;
  logic                next_pin;
  logic                next_pin_oe;
  logic [DATA_W-1:0]   next_rdata;
  logic                wr_ctrl;
  logic                wr_stat;
  logic                wr_mask;
  logic                rd_ctrl;
  logic                rd_stat;
  logic                rd_mask;
  logic                latch_now;

  aco_sync u_sync (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .async_in   (cmp_raw_in),
    .sync_out   (raw_sync)
  );

  aco_irq u_irq (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .irq_bus    (irq_bus)
  );

  // Address decode of the register port.
  always_comb
  begin
    wr_ctrl   = ce_in && reg_wr_in && (reg_addr_in == CTRL_ADDR);
    wr_stat   = ce_in && reg_wr_in && (reg_addr_in == IRQ_STAT_ADDR);
    wr_mask   = ce_in && reg_wr_in && (reg_addr_in == IRQ_MASK_ADDR);
    rd_ctrl   = reg_rd_in && (reg_addr_in == CTRL_ADDR);
    rd_stat   = reg_rd_in && (reg_addr_in == IRQ_STAT_ADDR);
    rd_mask   = reg_rd_in && (reg_addr_in == IRQ_MASK_ADDR);
    latch_now = ce_in && instr_cycle_end_in;
  end

  // Control register; the result bit is not stored, so writes to it drop.
  always_comb
  begin
    next_ctrl = ctrl;
    next_mask = irq_mask;
    if (wr_ctrl)
      next_ctrl = reg_wdata_in & CTRL_WR_MASK;  // [RULE2] [RULE12]
    if (wr_mask)
      next_mask = reg_wdata_in[CHG_BIT];
  end

  // One-hot input select: code n routes upper analog pin four plus n.
  always_comb
  begin
    next_input_sel = SEL_ONE << next_ctrl[SEL_LSB +: SEL_W];  // [RULE3] [RULE14]
  end

  // Internal result is sampled only at the end of an instruction cycle.
  always_comb
  begin
    next_result = result_q;
    if (instr_cycle_end_in)
      next_result = aco_eval(raw_sync, ctrl[EN_BIT],
                             ctrl[INV_BIT]);  // [RULE8] [RULE9]
  end

  // Pin path follows the comparator every clock, without the cycle latch.
  // Its enable ignores the comparator enable, so a disabled comparator
  // with pin drive set holds the pin low whatever the polarity bit.
  always_comb
  begin
    next_pin    = aco_eval(raw_sync, ctrl[EN_BIT], ctrl[INV_BIT]);  // [RULE9]
    next_pin_oe = ctrl[DRV_BIT]
                  && !switch_mode_controller_on_in
                  && !portb_direction_in[PORTB_PIN];  // [RULE7] [RULE11]
  end

  // The change event does not look at the pin drive bit at all.
  always_comb
  begin
    irq_bus.evt  = latch_now && (next_result != result_q);  // [RULE10] [RULE13]
    irq_bus.clr  = wr_stat && reg_wdata_in[CHG_BIT];
    irq_bus.mask = irq_mask;
  end

  // Read data stand for exactly one cycle after the strobe.
  always_comb
  begin
    next_rdata = RD_IDLE;
    if (rd_ctrl)
    begin
      next_rdata          = ctrl;
      next_rdata[RES_BIT] = result_q;  // [RULE6]
    end
    else if (rd_stat)
      next_rdata[CHG_BIT] = irq_bus.status;
    else if (rd_mask)
      next_rdata[CHG_BIT] = irq_mask;
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ctrl                  <= CTRL_RST;  // [RULE1]
      irq_mask              <= IRQ_RST[CHG_BIT];
      result_q              <= 1'b0;
      cmp_one_input_sel_out <= SEL_ONE;
      cmp_pin_out           <= 1'b0;
      cmp_pin_oe_out        <= 1'b0;
      reg_rdata_out         <= RD_IDLE;
    end
    else if (ce_in)
    begin
      ctrl                  <= next_ctrl;
      irq_mask              <= next_mask;
      result_q              <= next_result;
      cmp_one_input_sel_out <= next_input_sel;
      cmp_pin_out           <= next_pin;
      cmp_pin_oe_out        <= next_pin_oe;
      reg_rdata_out         <= next_rdata;
    end
  end

  // Analog controls come straight from the control register bits.
  always_comb
  begin
    cmp_one_enable_out  = ctrl[EN_BIT];  // [RULE2]
    cmp_one_fast_out    = ctrl[FAST_BIT];  // [RULE12]
    cmp_one_ref_sel_out = ctrl[REF_BIT];  // [RULE5]
    irq_out             = irq_bus.irq;
    wake_out            = irq_bus.status;  // [RULE13]
  end

  a_reset_values: assert property (@(posedge clk_sys_in)  // [RULE1]
    disable iff (!reset_n_in)
    $rose(reset_n_in) |-> (ctrl == CTRL_RST) && !irq_out && !cmp_pin_oe_out)
    else $error("Registers not at reset values after reset.");

  a_enable_write: assert property (@(posedge clk_sys_in)  // [RULE2]
    disable iff (!reset_n_in)
    wr_ctrl |=> cmp_one_enable_out == $past(reg_wdata_in[EN_BIT]))
    else $error("Enable output does not follow the written bit.");

  a_input_route: assert property (@(posedge clk_sys_in)  // [RULE3]
    disable iff (!reset_n_in)
    wr_ctrl |=> cmp_one_input_sel_out
                == (SEL_ONE << $past(reg_wdata_in[SEL_LSB +: SEL_W])))
    else $error("Input select does not route the coded pin.");

  a_onehot_sel: assert property (@(posedge clk_sys_in)  // [RULE14]
    disable iff (!reset_n_in)
    $onehot(cmp_one_input_sel_out))
    else $error("Input select is not one-hot.");

  a_ref_select: assert property (@(posedge clk_sys_in)  // [RULE5]
    disable iff (!reset_n_in)
    wr_ctrl |=> cmp_one_ref_sel_out == $past(reg_wdata_in[REF_BIT]))
    else $error("Reference select does not follow the written bit.");

  a_result_read: assert property (@(posedge clk_sys_in)  // [RULE6]
    disable iff (!reset_n_in)
    (ce_in && rd_ctrl) |=> reg_rdata_out[RES_BIT] == $past(result_q))
    else $error("Read of result bit disagrees with latched result.");

  a_result_ro: assert property (@(posedge clk_sys_in)  // [RULE6]
    disable iff (!reset_n_in)
    wr_ctrl |=> !ctrl[RES_BIT])
    else $error("Result bit was written by software.");

  a_pin_gate: assert property (@(posedge clk_sys_in)  // [RULE7]
    disable iff (!reset_n_in)
    ($past(ce_in) && cmp_pin_oe_out) |-> $past(ctrl[DRV_BIT])
      && !$past(switch_mode_controller_on_in)
      && !$past(portb_direction_in[PORTB_PIN]))  // [RULE11]
    else $error("Pin driven while drive conditions are not met.");

  a_polarity_res: assert property (@(posedge clk_sys_in)  // [RULE8]
    disable iff (!reset_n_in)
    (latch_now && ctrl[EN_BIT])
      |=> result_q == ($past(raw_sync) ^ $past(ctrl[INV_BIT])))
    else $error("Latched result has the wrong polarity.");

  a_latch_hold: assert property (@(posedge clk_sys_in)  // [RULE9]
    disable iff (!reset_n_in)
    !latch_now |=> $stable(result_q))
    else $error("Result changed outside an instruction cycle end.");

  a_change_flag: assert property (@(posedge clk_sys_in)  // [RULE13]
    disable iff (!reset_n_in)
    (ce_in && $changed(result_q)) |-> irq_bus.status ##1 wake_out)
    else $error("Result change did not raise the change flag.");

  a_irq_level: assert property (@(posedge clk_sys_in)  // [RULE10]
    disable iff (!reset_n_in)
    $past(ce_in) && irq_out |-> $past(irq_mask))
    else $error("Interrupt raised while masked.");

  a_fast_mode: assert property (@(posedge clk_sys_in)  // [RULE12]
    disable iff (!reset_n_in)
    wr_ctrl |=> cmp_one_fast_out == $past(reg_wdata_in[FAST_BIT]))
    else $error("Speed output does not follow the written bit.");

  a_read_idle: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    (ce_in && !reg_rd_in) |=> reg_rdata_out == RD_IDLE)
    else $error("Read data present without a read strobe.");

  a_pin_follow: assert property (@(posedge clk_sys_in)  // [RULE9]
    disable iff (!reset_n_in)
    ce_in |=> cmp_pin_out == ($past(ctrl[EN_BIT])
                              & ($past(raw_sync) ^ $past(ctrl[INV_BIT]))))
    else $error("Pin level does not follow the comparator.");

  a_disabled_zero: assert property (@(posedge clk_sys_in)  // [RULE2]
    disable iff (!reset_n_in)
    (latch_now && !ctrl[EN_BIT]) |=> !result_q)
    else $error("Disabled comparator latched a one.");

  a_sel_hold: assert property (@(posedge clk_sys_in)  // [RULE3]
    disable iff (!reset_n_in)
    (ce_in && !wr_ctrl) |=> $stable(cmp_one_input_sel_out))
    else $error("Input select moved without a control write.");

  a_oe_follow: assert property (@(posedge clk_sys_in)  // [RULE7] [RULE11]
    disable iff (!reset_n_in)
    (ce_in && ctrl[DRV_BIT] && !switch_mode_controller_on_in
      && !portb_direction_in[PORTB_PIN]) |=> cmp_pin_oe_out)
    else $error("Pin not driven although drive conditions hold.");

  a_irq_follow: assert property (@(posedge clk_sys_in)  // [RULE13]
    disable iff (!reset_n_in)
    (ce_in && irq_bus.status && irq_mask && !irq_bus.clr) |=> irq_out)
    else $error("Unmasked flag did not raise the interrupt.");

  a_flag_clear: assert property (@(posedge clk_sys_in)  // [RULE13]
    disable iff (!reset_n_in)
    (ce_in && irq_bus.clr && !irq_bus.evt) |=> !irq_bus.status)
    else $error("Writing one to the flag did not clear it.");

  a_mask_write: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    wr_mask |=> irq_mask == $past(reg_wdata_in[CHG_BIT]))
    else $error("Mask bit does not follow the written bit.");

  a_ce_freeze: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    !ce_in |=> $stable(ctrl) && $stable(result_q) && $stable(irq_out))
    else $error("State moved while the clock enable was low.");

endmodule

`default_nettype wire

// File: aco_analog_model.sv
// Behavioural model of the analog pins and reference of comparator one.
// Assumes the bench sets pin and reference levels as 8-bit codes.
`default_nettype none

module aco_analog_model
  import aco_pkg::*;
(
  input  wire logic [N_INPUT-1:0] input_sel_in,
  input  wire logic               ref_sel_in,
  input  wire logic               enable_in,
  input  wire logic [31:0]        pin_level_in,
  input  wire logic [7:0]         dac_level_in,
  input  wire logic [7:0]         vref_level_in,
  output logic                    raw_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] neg_level;
  logic [7:0] pos_level;

  // The selected pin feeds the negative input, the reference the positive.
  always_comb
  begin
    neg_level = 8'h00;
    for (int i = 0; i < N_INPUT; i++)
    begin
      if (input_sel_in[i])
      begin
        neg_level = pin_level_in[i*8 +: 8];
      end
    end
    pos_level = ref_sel_in ? dac_level_in : vref_level_in;
    raw_out = enable_in & (pos_level > neg_level);
  end
endmodule

`default_nettype wire

// File: aco_top_tb_top.sv
// Self-checking bench for the comparator one control block.
// Assumes the analog model stands in for the pins and the DAC reference.
`default_nettype none

module aco_top_tb_top
  import aco_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // Upper pins are used as analog inputs only, at fixed levels.
  localparam logic [31:0] PIN_LVL = 32'hD0905010;
  localparam logic [7:0]  DAC_LVL = 8'h80;
  localparam logic [7:0]  VREF_LVL = 8'h40;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic instr_end = 1'b0;
  logic [7:0] portb_dir = 8'h00;
  logic smc_on = 1'b0;
  logic [7:0] rdata;
  logic en_out, fast_out, ref_out, pin_out, oe_out, irq, wake, raw;
  logic [N_INPUT-1:0] sel_out;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  aco_top dut_u (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .ce_in(ce), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .cmp_raw_in(raw), .instr_cycle_end_in(instr_end),
    .portb_direction_in(portb_dir),
    .switch_mode_controller_on_in(smc_on),
    .cmp_one_enable_out(en_out), .cmp_one_fast_out(fast_out),
    .cmp_one_ref_sel_out(ref_out), .cmp_one_input_sel_out(sel_out),
    .cmp_pin_out(pin_out), .cmp_pin_oe_out(oe_out), .irq_out(irq),
    .wake_out(wake));

  aco_analog_model model_u (.input_sel_in(sel_out), .ref_sel_in(ref_out),
    .enable_in(en_out), .pin_level_in(PIN_LVL), .dac_level_in(DAC_LVL),
    .vref_level_in(VREF_LVL), .raw_out(raw));

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_in);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp,
                          input string what);
    @(posedge clk_sys_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1;
    check(what, exp, rdata);
  endtask

  // Lets the synchroniser settle, then ends one instruction cycle.
  task automatic latch_result();
    repeat (6) @(posedge clk_sys_in);
    instr_end <= 1'b1;
    @(posedge clk_sys_in);
    instr_end <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic check_reset();
    rd_check(CTRL_ADDR, 8'h00, "control");
    rd_check(IRQ_STAT_ADDR, 8'h00, "status");
    rd_check(IRQ_MASK_ADDR, 8'h00, "mask");
    check("outputs", 8'h00, {en_out, fast_out, ref_out, pin_out, oe_out,
                             irq, wake, 1'b0});
    check("select", 8'h01, {4'h0, sel_out});
  endtask

  initial
  begin
    logic [1:0] code;
    logic [7:0] wv;
    logic [7:0] e;
    repeat (8) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    check_reset();
    $display("test reset values done");
    // Every select code with both polarities and both references.
    for (int c = 0; c < 16; c++)
    begin
      code = c[1:0];
      wv = {2'b11, 1'b0, c[2], c[0], c[3], code};
      reg_write(CTRL_ADDR, wv);
      latch_result();
      e = {7'h00, ((c[3] ? DAC_LVL : VREF_LVL) >
                   PIN_LVL[code*8 +: 8]) ^ c[2]};
      check("enable", 8'h01, {7'h00, en_out});
      check("select", 8'h01 << code, {4'h0, sel_out});
      check("reference", {7'h00, c[3]}, {7'h00, ref_out});
      check("speed", {7'h00, c[0]}, {7'h00, fast_out});
      rd_check(CTRL_ADDR, (wv & CTRL_WR_MASK) | (e << RES_BIT),
               "control");
    end
    reg_write(CTRL_ADDR, 8'h14);
    latch_result();
    rd_check(CTRL_ADDR, 8'h14, "disabled");
    reg_write(IRQ_STAT_ADDR, 8'h01);
    reg_write(IRQ_MASK_ADDR, 8'h01);
    rd_check(IRQ_STAT_ADDR, 8'h00, "status");
    $display("test fields and result done");
    // Pin path follows at once; the readable result waits for the strobe.
    reg_write(CTRL_ADDR, 8'hA4);
    repeat (8) @(posedge clk_sys_in);
    #1;
    check("pin level", 8'h01, {7'h00, pin_out});
    rd_check(CTRL_ADDR, 8'hA4, "unlatched");
    check("irq early", 8'h00, {7'h00, irq});
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys_in);
      portb_dir <= {1'b0, i[0], 6'h3F};
      smc_on <= i[1];
      repeat (3) @(posedge clk_sys_in);
      #1;
      check("pin enable", {7'h00, i == 0}, {7'h00, oe_out});
    end
    latch_result();
    rd_check(CTRL_ADDR, 8'hE4, "latched");
    rd_check(IRQ_STAT_ADDR, 8'h01, "status");
    check("irq", 8'h03, {6'h00, irq, wake});
    reg_write(IRQ_STAT_ADDR, 8'h01);
    repeat (2) @(posedge clk_sys_in);
    rd_check(IRQ_STAT_ADDR, 8'h00, "cleared");
    check("irq cleared", 8'h00, {6'h00, irq, wake});
    reg_write(IRQ_MASK_ADDR, 8'h00);
    reg_write(CTRL_ADDR, 8'h94);
    repeat (3) @(posedge clk_sys_in);
    #1;
    check("pin off", 8'h00, {7'h00, oe_out});
    latch_result();
    rd_check(IRQ_STAT_ADDR, 8'h01, "status");
    check("masked", 8'h01, {6'h00, irq, wake});
    $display("test pin and interrupt done");
    reg_write(8'h07, 8'hFF);
    rd_check(8'h07, RD_IDLE, "unmapped");
    // A write while the clock enable is low must leave the control alone.
    @(posedge clk_sys_in);
    ce <= 1'b0;
    reg_write(CTRL_ADDR, 8'h00);
    @(posedge clk_sys_in);
    ce <= 1'b1;
    rd_check(CTRL_ADDR, 8'h94, "control kept");
    check("enable kept", 8'h01, {7'h00, en_out});
    @(posedge clk_sys_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    check_reset();
    $display("test unmapped, freeze and second reset done");
    end_of_test();
  end
endmodule

`default_nettype wire
